// File: fpcd_map.svh
`ifndef FPCD_MAP_SVH
`define FPCD_MAP_SVH
// register offsets on haddr[7:0]
`define FPCD_OFS_CTRL 8'h00
`define FPCD_OFS_ADDR 8'h04
`define FPCD_OFS_WDATA 8'h08
`define FPCD_OFS_STATUS 8'h0C
`define FPCD_OFS_RDATA 8'h10
`define FPCD_OFS_PWD_LO 8'h14
`define FPCD_OFS_PWD_HI 8'h18
// field positions
`define FPCD_CTRL_CMD_LSB 0
`define FPCD_CTRL_BYTE_BIT 8
`define FPCD_CTRL_CODE_LSB 16
`define FPCD_STAT_BUSY_BIT 0
`define FPCD_STAT_DONE_BIT 1
`define FPCD_STAT_PROT_BIT 2
`define FPCD_STAT_GAP_BIT 3
`define FPCD_CMD_COUNT 4'hA
`define FPCD_PWD_RST 64'hFFFFFFFFFFFFFFFF
// flash unlock addresses and codes
`define FPCD_U1_X8 32'h00000AAA
`define FPCD_U2_X8 32'h00000555
`define FPCD_U1_X16 32'h00000555
`define FPCD_U2_X16 32'h000002AA
`define FPCD_EXT_EXIT_ADDR 32'h00000555
`define FPCD_D_AA 16'h00AA
`define FPCD_D_55 16'h0055
`define FPCD_D_A0 16'h00A0
`define FPCD_D_90 16'h0090
`define FPCD_D_00 16'h0000
`define FPCD_D_80 16'h0080
`define FPCD_D_30 16'h0030
`define FPCD_D_25 16'h0025
`define FPCD_D_03 16'h0003
`define FPCD_D_29 16'h0029
// timing, ns, and clock rate
`define FPCD_CLK_MHZ 100
`define FPCD_T_SETUP_NS 20
`define FPCD_T_WR_NS 50
`define FPCD_T_RD_NS 120
`define FPCD_T_HOLD_NS 30
`define FPCD_T_UNLOCK_GAP_NS 1000
`define FPCD_NS2CYC(ns) (((ns) * `FPCD_CLK_MHZ + 999) / 1000)
`endif

// File: fpcd_pkg.sv
`default_nettype none
package fpcd_pkg;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_ENTER, CMD_EXIT, CMD_EXIT_EXT, CMD_PROG,
    CMD_READ, CMD_CLEAR_ALL, CMD_PWD_PROG, CMD_PWD_READ, CMD_PWD_UNLOCK
  } fpcd_cmd_t;
  typedef struct packed {
    logic wr;
    logic last;
    logic [31:0] a;
    logic [15:0] d;
  } fpcd_cyc_t;
endpackage : fpcd_pkg
`default_nettype wire

// File: fpcd_cyc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fpcd_cyc_if #(
  parameter int ADDR_W = 26
);
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport engine (input req, wr, addr, wdata, output done, rdata);
endinterface : fpcd_cyc_if
`default_nettype wire

// File: fpcd_cycle.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpcd_map.svh"
module fpcd_cycle #(
  parameter int ADDR_W = 26
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // cycle requests
  fpcd_cyc_if.engine cyc,
  // flash pins
  output logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o
);
  import fpcd_pkg::*;
  typedef enum {C_IDLE, C_SETUP, C_PULSE, C_HOLD} fpcd_cst_t;
  localparam logic [7:0] SETUP_CYC = 8'(`FPCD_NS2CYC(`FPCD_T_SETUP_NS));
  localparam logic [7:0] WR_CYC = 8'(`FPCD_NS2CYC(`FPCD_T_WR_NS));
  localparam logic [7:0] RD_CYC = 8'(`FPCD_NS2CYC(`FPCD_T_RD_NS));
  localparam logic [7:0] HOLD_CYC = 8'(`FPCD_NS2CYC(`FPCD_T_HOLD_NS));
  fpcd_cst_t st_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;
  logic done_reg;
  logic [15:0] dq_s1_reg;
  logic [15:0] dq_s2_reg;
  logic [15:0] rdata_reg;
  assign cyc.done = done_reg;
  assign cyc.rdata = rdata_reg;
  // dq synchroniser
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
    end else begin
      dq_s1_reg <= flash_dq_i;
      dq_s2_reg <= dq_s1_reg;
    end
  end
  // setup, strobe, hold sequence; a read is a plain oe strobe
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= C_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      flash_addr_o <= '0;
      flash_dq_o <= 16'h0000;
      flash_dq_oe_o <= 1'b0;
      flash_ce_n_o <= 1'b1;
      flash_oe_n_o <= 1'b1;
      flash_we_n_o <= 1'b1;
    end else begin
      done_reg <= 1'b0;
      case (st_reg)
        C_IDLE: if (cyc.req) begin
          st_reg <= C_SETUP;
          cnt_reg <= SETUP_CYC - 8'h01;
          wr_reg <= cyc.wr;
          flash_addr_o <= cyc.addr;
          flash_dq_o <= cyc.wdata;
          flash_dq_oe_o <= cyc.wr;
          flash_ce_n_o <= 1'b0;
        end
        C_SETUP: if (cnt_reg == 8'h00) begin
          st_reg <= C_PULSE;
          cnt_reg <= (wr_reg ? WR_CYC : RD_CYC) - 8'h01;
          flash_we_n_o <= ~wr_reg;
          flash_oe_n_o <= wr_reg;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        C_PULSE: if (cnt_reg == 8'h00) begin
          st_reg <= C_HOLD;
          cnt_reg <= HOLD_CYC - 8'h01;
          flash_we_n_o <= 1'b1;
          flash_oe_n_o <= 1'b1;
          if (!wr_reg) begin
            rdata_reg <= dq_s2_reg;
          end
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        C_HOLD: if (cnt_reg == 8'h00) begin
          st_reg <= C_IDLE;
          flash_ce_n_o <= 1'b1;
          flash_dq_oe_o <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        default: st_reg <= C_IDLE;
      endcase
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence seq_wr_strobe;
    !flash_we_n_o [*5] ##1 flash_we_n_o;
  endsequence
  a_we_pulse_width: assert property ($fell(flash_we_n_o) |-> seq_wr_strobe)
    else $error("write strobe width wrong");
  a_strobe_exclusive: assert property (!(!flash_we_n_o && !flash_oe_n_o))
    else $error("we and oe low together");
  a_write_drives_dq: assert property (!flash_we_n_o |-> flash_dq_oe_o && !flash_ce_n_o)
    else $error("write strobe without data drive");
endmodule : fpcd_cycle
`default_nettype wire

// File: fpcd_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpcd_map.svh"
// Operation
// - every command set opens with AA, 55 at the unlock pair, then set code.
// - leave a set with 90 then 00 at any address.
// - register, status and password reads are plain ce and oe reads.
// - read-type commands use bus reads only, never writes.
// - protection encoding 00 protected, 01 unprotected; status on data bit 0.
// - volatile bit write: A0 anywhere, then 00 or 01 inside the block.
// - password is eight bytes or four words, each at its own portion address.
// - one program command writes exactly one password portion.
// - byte password read is eight reads at addresses 00 to 07.
// - byte unlock: 25, 03 at 00, eight bytes at 00-07, 29 at 00.
// - word unlock: 25, 03, four words at 00-03, then 29.
// - all command addresses and data are hexadecimal values.
// - unlock attempts spaced at least 1 us apart.
module fpcd_top #(
  parameter int ADDR_W = 26
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // flash pins
  output logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_byte_n_o
);
  import fpcd_pkg::*;
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie in 12..32");
  end
  typedef enum {S_IDLE, S_GAP, S_ISSUE, S_WAIT} fpcd_st_t;
  localparam logic [7:0] GAP_CYC = 8'(`FPCD_NS2CYC(`FPCD_T_UNLOCK_GAP_NS));

  fpcd_cyc_if #(.ADDR_W(ADDR_W)) cyc ();

  // ahb state
  logic wr_pend_reg;
  logic [7:0] wr_ofs_reg;
  logic [31:0] hrdata_reg;
  // software registers
  logic byte_mode_reg;
  logic [7:0] set_code_reg;
  logic [31:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [63:0] pwd_reg;
  logic [15:0] rdata_reg;
  logic done_reg;
  // sequencer
  fpcd_st_t st_reg;
  fpcd_cmd_t cmd_reg;
  logic [3:0] step_reg;
  logic [7:0] gap_cnt_reg;
  logic req_reg;
  logic cyc_wr_reg;
  logic [ADDR_W-1:0] cyc_addr_reg;
  logic [15:0] cyc_wdata_reg;
  fpcd_cyc_t cur;

  // one password portion, byte or word wide
  function automatic logic [15:0] portion(input logic [63:0] pw, input logic bm, input logic [2:0] k);
    portion = bm ? {8'h00, pw[{k, 3'b000} +: 8]} : pw[{k[1:0], 4'h0} +: 16];
  endfunction : portion

  // unlock pair cycle for step 0 or 1
  function automatic fpcd_cyc_t unl(input logic bm, input logic second);
    fpcd_cyc_t r;
    r.wr = 1'b1;
    r.last = 1'b0;
    r.a = second ? (bm ? `FPCD_U2_X8 : `FPCD_U2_X16) : (bm ? `FPCD_U1_X8 : `FPCD_U1_X16);
    r.d = second ? `FPCD_D_55 : `FPCD_D_AA;
    return r;
  endfunction : unl

  // cycle s of command c
  function automatic fpcd_cyc_t step_cycle(input fpcd_cmd_t c, input logic [3:0] s, input logic bm,
      input logic [7:0] code, input logic [31:0] a, input logic [15:0] d, input logic [63:0] pw);
    fpcd_cyc_t r;
    logic [3:0] n;
    logic [3:0] k;
    r = '{wr: 1'b1, last: 1'b0, a: 32'h00000000, d: `FPCD_D_00};
    n = bm ? 4'h8 : 4'h4;
    k = s - 4'h2;
    case (c)
      CMD_ENTER: begin
        if (s < 4'h2) begin
          r = unl(bm, s[0]);
        end else begin
          r.a = bm ? `FPCD_U1_X8 : `FPCD_U1_X16;
          r.d = {8'h00, code};
          r.last = 1'b1;
        end
      end
      CMD_EXIT: begin
        r.d = (s == 4'h0) ? `FPCD_D_90 : `FPCD_D_00;
        r.last = (s != 4'h0);
      end
      CMD_EXIT_EXT: begin
        if (s < 4'h2) begin
          r = unl(bm, s[0]);
        end else if (s == 4'h2) begin
          r.a = `FPCD_EXT_EXIT_ADDR;
          r.d = `FPCD_D_90;
        end else begin
          r.last = 1'b1;
        end
      end
      CMD_PROG: begin
        if (s == 4'h0) begin
          r.d = `FPCD_D_A0;
        end else begin
          r.a = a;
          r.d = bm ? {8'h00, d[7:0]} : d;
          r.last = 1'b1;
        end
      end
      CMD_READ: begin
        r.wr = 1'b0;
        r.a = a;
        r.last = 1'b1;
      end
      CMD_CLEAR_ALL: begin
        r.d = (s == 4'h0) ? `FPCD_D_80 : `FPCD_D_30;
        r.last = (s != 4'h0);
      end
      CMD_PWD_PROG: begin
        if (s == 4'h0) begin
          r.d = `FPCD_D_A0;
        end else begin
          r.a = bm ? {29'h0, a[2:0]} : {30'h0, a[1:0]};
          r.d = bm ? {8'h00, d[7:0]} : d;
          r.last = 1'b1;
        end
      end
      CMD_PWD_READ: begin
        r.wr = 1'b0;
        r.a = {28'h0, s};
        r.last = (s == n - 4'h1);
      end
      CMD_PWD_UNLOCK: begin
        if (s == 4'h0) begin
          r.d = `FPCD_D_25;
        end else if (s == 4'h1) begin
          r.d = `FPCD_D_03;
        end else if (s < n + 4'h2) begin
          r.a = {28'h0, k};
          r.d = portion(pw, bm, k[2:0]);
        end else begin
          r.d = `FPCD_D_29;
          r.last = 1'b1;
        end
      end
      default: r.last = 1'b1;
    endcase
    return r;
  endfunction : step_cycle

  // register read decode
  function automatic logic [31:0] rd_word(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h00000000;
    case (ofs)
      `FPCD_OFS_CTRL: begin
        v[`FPCD_CTRL_BYTE_BIT] = byte_mode_reg;
        v[`FPCD_CTRL_CODE_LSB +: 8] = set_code_reg;
      end
      `FPCD_OFS_ADDR: v = addr_reg;
      `FPCD_OFS_WDATA: v[15:0] = wdata_reg;
      `FPCD_OFS_STATUS: begin
        v[`FPCD_STAT_BUSY_BIT] = (st_reg != S_IDLE);
        v[`FPCD_STAT_DONE_BIT] = done_reg;
        v[`FPCD_STAT_PROT_BIT] = ~rdata_reg[0];
        v[`FPCD_STAT_GAP_BIT] = (gap_cnt_reg != 8'h00);
      end
      `FPCD_OFS_RDATA: v[15:0] = rdata_reg;
      `FPCD_OFS_PWD_LO: v = pwd_reg[31:0];
      `FPCD_OFS_PWD_HI: v = pwd_reg[63:32];
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction : rd_word

  // ahb-lite slave, zero wait states
  wire take = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= take && hwrite_i;
      if (take) begin
        wr_ofs_reg <= haddr_i[7:0];
      end
      hrdata_reg <= (take && !hwrite_i) ? rd_word(haddr_i[7:0]) : 32'h00000000;
    end
  end

  wire wr_ctrl = wr_pend_reg && (wr_ofs_reg == `FPCD_OFS_CTRL);
  wire [3:0] wr_cmd_raw = hwdata_i[`FPCD_CTRL_CMD_LSB +: 4];
  fpcd_cmd_t wr_cmd;
  assign wr_cmd = fpcd_cmd_t'(wr_cmd_raw);
  wire start = wr_ctrl && (wr_cmd_raw != 4'h0) && (wr_cmd_raw < `FPCD_CMD_COUNT) && (st_reg == S_IDLE);
  wire finish = (st_reg == S_WAIT) && cyc.done && cur.last;

  assign cur = step_cycle(cmd_reg, step_reg, byte_mode_reg, set_code_reg, addr_reg, wdata_reg, pwd_reg);

  // configuration registers, frozen while busy
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_mode_reg <= 1'b0;
      set_code_reg <= 8'h00;
      addr_reg <= 32'h00000000;
      wdata_reg <= 16'h0000;
    end else if (wr_pend_reg && st_reg == S_IDLE) begin
      case (wr_ofs_reg)
        `FPCD_OFS_CTRL: begin
          byte_mode_reg <= hwdata_i[`FPCD_CTRL_BYTE_BIT];
          set_code_reg <= hwdata_i[`FPCD_CTRL_CODE_LSB +: 8];
        end
        `FPCD_OFS_ADDR: addr_reg <= hwdata_i;
        `FPCD_OFS_WDATA: wdata_reg <= hwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // sequencer; unlock waits out the spacing gap
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= S_IDLE;
      cmd_reg <= CMD_NONE;
      step_reg <= 4'h0;
    end else begin
      case (st_reg)
        S_IDLE: if (start) begin
          cmd_reg <= wr_cmd;
          step_reg <= 4'h0;
          st_reg <= (wr_cmd == CMD_PWD_UNLOCK && gap_cnt_reg != 8'h00) ? S_GAP : S_ISSUE;
        end
        S_GAP: if (gap_cnt_reg == 8'h00) begin
          st_reg <= S_ISSUE;
        end
        S_ISSUE: st_reg <= S_WAIT;
        S_WAIT: if (cyc.done) begin
          if (cur.last) begin
            st_reg <= S_IDLE;
          end else begin
            step_reg <= step_reg + 4'h1;
            st_reg <= S_ISSUE;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // cycle request to the engine
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_reg <= 1'b0;
      cyc_wr_reg <= 1'b0;
      cyc_addr_reg <= '0;
      cyc_wdata_reg <= 16'h0000;
    end else begin
      req_reg <= (st_reg == S_ISSUE);
      if (st_reg == S_ISSUE) begin
        cyc_wr_reg <= cur.wr;
        cyc_addr_reg <= cur.a[ADDR_W-1:0];
        cyc_wdata_reg <= cur.d;
      end
    end
  end
  assign cyc.req = req_reg;
  assign cyc.wr = cyc_wr_reg;
  assign cyc.addr = cyc_addr_reg;
  assign cyc.wdata = cyc_wdata_reg;

  // unlock spacing counter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_cnt_reg <= 8'h00;
    end else if (finish && cmd_reg == CMD_PWD_UNLOCK) begin
      gap_cnt_reg <= GAP_CYC;
    end else if (gap_cnt_reg != 8'h00) begin
      gap_cnt_reg <= gap_cnt_reg - 8'h01;
    end
  end

  // done flag: completion beats a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end else if (wr_pend_reg && wr_ofs_reg == `FPCD_OFS_STATUS && hwdata_i[`FPCD_STAT_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // read data and password capture
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 16'h0000;
      pwd_reg <= `FPCD_PWD_RST;
    end else begin
      if (wr_pend_reg && st_reg == S_IDLE && wr_ofs_reg == `FPCD_OFS_PWD_LO) begin
        pwd_reg[31:0] <= hwdata_i;
      end
      if (wr_pend_reg && st_reg == S_IDLE && wr_ofs_reg == `FPCD_OFS_PWD_HI) begin
        pwd_reg[63:32] <= hwdata_i;
      end
      if (st_reg == S_WAIT && cyc.done && !cyc_wr_reg) begin
        rdata_reg <= byte_mode_reg ? {8'h00, cyc.rdata[7:0]} : cyc.rdata;
        if (cmd_reg == CMD_PWD_READ && byte_mode_reg) begin
          pwd_reg[{step_reg[2:0], 3'b000} +: 8] <= cyc.rdata[7:0];
        end else if (cmd_reg == CMD_PWD_READ) begin
          pwd_reg[{step_reg[1:0], 4'h0} +: 16] <= cyc.rdata;
        end
      end
    end
  end

  fpcd_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .cyc(cyc),
    .flash_addr_o(flash_addr_o),
    .flash_dq_i(flash_dq_i),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o),
    .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o)
  );
  assign flash_byte_n_o = ~byte_mode_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_enter_first: assert property (req_reg && cmd_reg == CMD_ENTER && step_reg == 4'h0 |->
      cyc_wdata_reg == `FPCD_D_AA && cyc_wr_reg)
    else $error("enter does not open with AA");
  a_exit_pair: assert property (req_reg && cmd_reg == CMD_EXIT |->
      cyc_wdata_reg == (step_reg == 4'h0 ? `FPCD_D_90 : `FPCD_D_00))
    else $error("exit pair wrong");
  a_hi_byte_zero: assert property (req_reg && byte_mode_reg |-> cyc_wdata_reg[15:8] == 8'h00)
    else $error("upper byte driven in byte mode");
  a_reads_only: assert property (req_reg && (cmd_reg == CMD_READ || cmd_reg == CMD_PWD_READ) |->
      !cyc_wr_reg)
    else $error("read command issued a write");
  a_unlock_gap: assert property (req_reg && cmd_reg == CMD_PWD_UNLOCK && step_reg == 4'h0 |->
      gap_cnt_reg == 8'h00)
    else $error("unlock too soon");
  a_unlock_load: assert property (finish && cmd_reg == CMD_PWD_UNLOCK |=> gap_cnt_reg == GAP_CYC)
    else $error("gap counter not loaded");
  a_unlock_length: assert property (finish && cmd_reg == CMD_PWD_UNLOCK |->
      step_reg == (byte_mode_reg ? 4'hA : 4'h6))
    else $error("unlock cycle count wrong");
  a_pwd_read_len: assert property (finish && cmd_reg == CMD_PWD_READ |->
      step_reg == (byte_mode_reg ? 4'h7 : 4'h3))
    else $error("password read count wrong");
  a_done_sets: assert property (finish |=> done_reg && st_reg == S_IDLE)
    else $error("done not raised at end");
  a_start_busy: assert property (start |=> st_reg != S_IDLE)
    else $error("start not taken");
endmodule : fpcd_top
`default_nettype wire

// File: fpcd_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpcd_flash_model (
  // flash pins
  input wire logic [25:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic dq_oe_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic byte_n_i,
  // resolved data lines
  output logic [15:0] dq_o
);
  logic [7:0] mode;
  logic [63:0] pw, ub;
  logic [3:0] nv, vb;
  logic lockbit, pend90, pend80, arm;
  logic [15:0] rd, last;
  int st, ucnt, ulen, ignored, hi_bad;
  realtime last_unl, t25;
  wire logic [7:0] d = dq_i[7:0];
  wire logic [15:0] a = addr_i[15:0];
  wire logic [1:0] blk = addr_i[17:16];
  wire logic wbyte = !byte_n_i;
  wire logic drv = !ce_n_i && !oe_n_i;
  wire logic [15:0] u1 = wbyte ? 16'h0AAA : 16'h0555;
  wire logic [15:0] u2 = wbyte ? 16'h0555 : 16'h02AA;
  // released lines show the inverse of the last driven value
  assign dq_o = dq_oe_i ? dq_i : drv ? rd : ~last;
  initial begin
    mode = 8'h00;
    {pend90, pend80, arm} = 3'h0;
    {nv, vb} = 8'hFF;
    pw = '1;
    ub = '0;
    lockbit = 1'b1;
    last = 16'h0000;
    {st, ucnt, ulen, ignored, hi_bad} = '0;
    last_unl = -1.0e6;
  end
  always @(dq_o) if (dq_oe_i || drv) last = dq_o;
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (wbyte && dq_i[15:8] !== 8'h00) hi_bad++;
    if (ucnt >= 2) begin
      if (ucnt < (wbyte ? 10 : 6)) begin
        if (wbyte) ub[8*a[2:0] +: 8] = d;
        else ub[16*a[1:0] +: 16] = dq_i;
        ucnt++;
      end else begin
        ulen = ucnt + 1;
        ucnt = 0;
        if (d == 8'h29) begin
          if (t25 - last_unl < 1000.0) ignored++;
          else if (ub == pw) lockbit = 1'b1;
          last_unl = $realtime;
        end
      end
    end else if (ucnt == 1) ucnt = (d == 8'h03) ? 2 : 0;
    else if (arm) begin
      arm = 1'b0;
      case (mode)
        8'h60: if (wbyte) pw[8*a[2:0] +: 8] = d; else pw[16*a[1:0] +: 16] = dq_i;
        8'hC0: if (lockbit) nv[blk] = 1'b0;
        8'h50: lockbit = 1'b0;
        8'hE0: vb[blk] = d[0];
        default: ;
      endcase
    end else if (pend90) begin
      pend90 = 1'b0;
      if (d == 8'h00) mode = 8'h00;
    end else if (pend80) begin
      pend80 = 1'b0;
      if (d == 8'h30 && lockbit) begin
        nv = 4'h0;
        nv = 4'hF;
      end
    end else if (st == 2) begin
      st = 0;
      if (d == 8'h90) pend90 = 1'b1;
      else if (a == u1) mode = d;
    end else if (st == 1) st = (a == u2 && d == 8'h55) ? 2 : 0;
    else if (a == u1 && d == 8'hAA) st = 1;
    else if (mode != 8'h00) begin
      if (d == 8'h90) pend90 = 1'b1;
      else if (d == 8'hA0) arm = 1'b1;
      else if (d == 8'h80) pend80 = 1'b1;
      else if (d == 8'h25 && mode == 8'h60) begin
        ucnt = 1;
        t25 = $realtime;
      end
    end
  end
  // register reads carry no command code
  always_comb begin
    case (mode)
      8'h60: rd = wbyte ? {8'h00, pw[8*a[2:0] +: 8]} : pw[16*a[1:0] +: 16];
      8'hC0: rd = {15'h0000, nv[blk]};
      8'h50: rd = {15'h0000, lockbit};
      8'hE0: rd = {15'h0000, vb[blk] & nv[blk]};
      default: rd = ~a;
    endcase
  end
endmodule : fpcd_flash_model
`default_nettype wire

// File: fpcd_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpcd_map.svh"
module fpcd_test;
  import fpcd_pkg::*;
  typedef struct packed {
    logic [3:0] c;
    logic [7:0] code;
    logic [19:0] a;
    logic [15:0] wd;
    logic [7:0] ofs;
    logic [31:0] exp;
  } fpcd_row_t;
  localparam fpcd_row_t ROWS [30] = '{
    '{4'h1, 8'hE0, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h4, 8'h00, 20'h10000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h5, 8'h00, 20'h10000, 16'h0000, 8'h10, 32'h00000000},
    '{4'h2, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h1, 8'hC0, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h4, 8'h00, 20'h20000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h5, 8'h00, 20'h20000, 16'h0000, 8'h10, 32'h00000000},
    '{4'h6, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h5, 8'h00, 20'h20000, 16'h0000, 8'h10, 32'h00000001},
    '{4'h4, 8'h00, 20'h20000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h2, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h1, 8'h50, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h4, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h5, 8'h00, 20'h00000, 16'h0000, 8'h10, 32'h00000000},
    '{4'h2, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h1, 8'hC0, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h6, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h5, 8'h00, 20'h20000, 16'h0000, 8'h10, 32'h00000000},
    '{4'h2, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h1, 8'h60, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h7, 8'h00, 20'h00002, 16'h3333, 8'hFF, 32'h00000000},
    '{4'h7, 8'h00, 20'h00000, 16'h1111, 8'hFF, 32'h00000000},
    '{4'h7, 8'h00, 20'h00003, 16'h4444, 8'hFF, 32'h00000000},
    '{4'h7, 8'h00, 20'h00001, 16'h2222, 8'hFF, 32'h00000000},
    '{4'h8, 8'h00, 20'h00000, 16'h0000, 8'h14, 32'h22221111},
    '{4'h0, 8'h00, 20'h00000, 16'h0000, 8'h18, 32'h44443333},
    '{4'h9, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h2, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h1, 8'h88, 20'h00000, 16'h0000, 8'hFF, 32'h00000000},
    '{4'h3, 8'h00, 20'h00000, 16'h0000, 8'hFF, 32'h00000000}
  };
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, s;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic hreadyout_o, hresp_o, flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_byte_n_o;
  logic [31:0] hrdata_o;
  logic [25:0] flash_addr_o;
  logic [15:0] flash_dq_i, flash_dq_o;
  int errors = 0, samples_checked = 0, i;
  always #5 ref_clk_i = ~ref_clk_i;
  fpcd_top #(.ADDR_W(26)) i_fpcd_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .flash_addr_o(flash_addr_o), .flash_dq_i(flash_dq_i), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o), .flash_byte_n_o(flash_byte_n_o));
  fpcd_flash_model i_fpcd_flash_model (.addr_i(flash_addr_o), .dq_i(flash_dq_o), .dq_oe_i(flash_dq_oe_o),
    .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .byte_n_i(flash_byte_n_o),
    .dq_o(flash_dq_i));
  task test_done;
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one bus phase: hready and read data taken at a rising edge
  task automatic wt(output logic [31:0] rd);
    logic r;
    for (int n = 0; n < 20; n++) begin
      @(posedge ref_clk_i);
      r = hreadyout_o;
      rd = hrdata_o;
      if (r === 1'b1) break;
    end
    if (r !== 1'b1) begin
      errors++;
      test_done();
    end
  endtask : wt
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    hsel_i <= 1'b1;
    haddr_i <= {24'h000000, ofs};
    hwrite_i <= wr;
    htrans_i <= 2'h2;
    wt(rd);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wt(rd);
  endtask : bus
  task automatic start(input logic [3:0] c, input logic [7:0] code, input logic [31:0] a,
      input logic [15:0] wd, input logic bm);
    bus(1'b1, `FPCD_OFS_ADDR, a, s);
    bus(1'b1, `FPCD_OFS_WDATA, {16'h0000, wd}, s);
    bus(1'b1, `FPCD_OFS_CTRL, {8'h00, code, 7'h00, bm, 4'h0, c}, s);
  endtask : start
  task automatic fin;
    for (int n = 0; n < 3000; n++) begin
      bus(1'b0, `FPCD_OFS_STATUS, 32'h0, s);
      if (s[1] === 1'b1) break;
    end
    if (s[1] !== 1'b1) begin
      errors++;
      test_done();
    end
    bus(1'b1, `FPCD_OFS_STATUS, 32'h2, s);
  endtask : fin
  initial begin
    repeat (20) @(posedge ref_clk_i);
    check("ce_n_in_reset", {26'h0, hresp_o, flash_dq_oe_o, flash_byte_n_o, flash_oe_n_o, flash_we_n_o, flash_ce_n_o}, 32'hF);
    rst_n_i <= 1'b1;
    bus(1'b0, `FPCD_OFS_STATUS, 32'h0, s);
    check("status_reset", s, 32'h4);
    bus(1'b0, `FPCD_OFS_PWD_HI, 32'h0, s);
    check("pwd_reset", s, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, 32'h0, s);
    check("unmapped", s, 32'h0);
    foreach (ROWS[k]) begin
      if (ROWS[k].c != 4'h0) begin
        start(ROWS[k].c, ROWS[k].code, {12'h000, ROWS[k].a}, ROWS[k].wd, 1'b0);
        fin();
      end
      if (ROWS[k].ofs != 8'hFF) begin
        bus(1'b0, ROWS[k].ofs, 32'h0, s);
        check($sformatf("row%0d", k), s, ROWS[k].exp);
      end
    end
    check("word_unlock_len", i_fpcd_flash_model.ulen, 32'd7);
    check("mode_after_exit", {24'h0, i_fpcd_flash_model.mode}, 32'h0);
    start(4'h1, 8'h60, 32'h0, 16'h0000, 1'b1);
    fin();
    for (i = 7; i >= 0; i--) begin
      start(4'h7, 8'h00, 32'(i), {8'h5A, 8'hA0 + 8'(i)}, 1'b1);
      fin();
    end
    start(4'h8, 8'h00, 32'h0, 16'h0000, 1'b1);
    fin();
    bus(1'b0, `FPCD_OFS_PWD_LO, 32'h0, s);
    check("pwd_lo_byte", s, 32'hA3A2A1A0);
    bus(1'b0, `FPCD_OFS_PWD_HI, 32'h0, s);
    check("pwd_hi_byte", s, 32'hA7A6A5A4);
    check("upper_byte_clear", i_fpcd_flash_model.hi_bad, 32'd0);
    start(4'h9, 8'h00, 32'h0, 16'h0000, 1'b1);
    fin();
    start(4'h9, 8'h00, 32'h0, 16'h0000, 1'b1);
    bus(1'b0, `FPCD_OFS_STATUS, 32'h0, s);
    check("gap_busy", {30'h0, s[3], s[0]}, 32'h3);
    fin();
    check("byte_unlock_len", i_fpcd_flash_model.ulen, 32'd11);
    check("unlock_ignored", i_fpcd_flash_model.ignored, 32'd0);
    bus(1'b0, `FPCD_OFS_CTRL, 32'h0, s);
    check("ctrl_readback", s, 32'h00000100);
    test_done();
  end
endmodule : fpcd_test
`default_nettype wire
